//--- hub_mode_pkg.sv
// Purpose: constants and types for the hub standby/operating mode control and port map
// Assumes: one 250 MHz clock from the internal pll, reset input active low
// Notes:   mapping tables are fixed; no software reaches any of this
//
// How it works
// [RL1] reset input low means standby, high means hub operation.
// [RL2] standby: everything idle except reset watch, ports floated, pll stopped.
// [RL3] entering standby disables downstream ports and aborts transactions immediately.
// [RL4] standby returns registers to defaults; configuration must reload after release.
// [RL5] standby removes core power for lowest power state.
// [RL6] with reset high the hub walks through its operating sub-stages.
// [RL7] silicon holds six usb3 phys and seven usb2 phys, physically numbered.
// [RL8] host sees logical numbering through a fixed remap of physical numbers.
// [RL9] each port setting is applied against physical or logical numbering as declared.
// [RL10] usb2 map: 0-0, 1-1, 4-2, 2-3, 3-5 logical to physical.
// [RL11] usb3 map: 0-0, 1A-1, 1B-2, 2A-3, 2B-4, 3-5.
// [RL12] on release: reset logic, let pll lock, load configuration defaults.
// [RL13] release of reset is synchronised before standby is left.
package hub_mode_pkg;

  // ==========================================================
  // phy counts and port numbering
  localparam int NUM_U3_PHY   = 6;
  localparam int NUM_U2_PHY   = 7;
  localparam int NUM_LOG_PORT = 5;
  localparam int NUM_U3_LANE  = 2;
  localparam int PORT_W       = 3;

  typedef logic [PORT_W-1:0] port_num_t;

  // ==========================================================
  // fixed remap tables, indexed by logical port
  localparam port_num_t U2_MAP [NUM_LOG_PORT] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h2};
  // lane a, lane b; single-lane ports repeat the same phy, port 4 has no usb3
  localparam port_num_t U3_MAP_A [NUM_LOG_PORT] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};
  localparam port_num_t U3_MAP_B [NUM_LOG_PORT] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h7};
  localparam logic [NUM_LOG_PORT-1:0] U3_PRESENT = 5'h0f;
  localparam logic [NUM_LOG_PORT-1:0] U3_TWO_LANE = 5'h06;

  // ==========================================================
  // timing
  localparam int CLK_MHZ        = 250;
  localparam int PLL_LOCK_NS    = 1000;
  localparam int PLL_LOCK_CYC   = (PLL_LOCK_NS * CLK_MHZ + 999) / 1000;
  localparam int LOCK_CNT_W     = 12;

  // ==========================================================
  // operating stages
  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_PLL_WAIT,
    ST_CFG_LOAD,
    ST_ATTACH,
    ST_NORMAL
  } hub_stage_e;

  typedef struct packed {
    logic core_pwr_en;
    logic pll_run;
    logic ports_drive;
    logic xact_enable;
    logic cfg_load;
  } hub_ctrl_s;

  localparam hub_ctrl_s CTRL_STANDBY = '{default: 1'b0};

endpackage

//--- hub_mode_ctrl.sv
// Purpose: standby/hub mode sequencing and logical-to-physical port lookup
// Assumes: i_reset_n is the system reset pin, asynchronous to i_clk
// Notes:   sub-stage progress after config load is handed off by firmware strobes
`timescale 1ns/1ps

module hub_mode_ctrl
  import hub_mode_pkg::*;
#(
  parameter int LOCK_CYC = PLL_LOCK_CYC
) (
  // clock and reset pin
  input  wire logic                    i_clk,
  input  wire logic                    i_reset_n,
  // pll and configuration handshake
  input  wire logic                    i_pll_locked,
  input  wire logic                    i_cfg_done,
  input  wire logic                    i_host_attached,
  input  wire logic                    i_soft_disconnect,
  // port setting lookup
  input  wire logic [PORT_W-1:0]       i_set_port,
  input  wire logic                    i_set_is_logical,
  input  wire logic [NUM_LOG_PORT-1:0] i_ds_port_en,
  // mode outputs
  output logic                         o_standby,
  output hub_ctrl_s                    o_ctrl,
  output hub_stage_e                   o_stage,
  output logic [NUM_U2_PHY-1:0]        o_u2_phy_en,
  output logic [NUM_U3_PHY-1:0]        o_u3_phy_en,
  output logic [PORT_W-1:0]            o_set_u2_phy,
  output logic [PORT_W-1:0]            o_set_u3_phy_a,
  output logic [PORT_W-1:0]            o_set_u3_phy_b
);

  // refuse lock waits the counter cannot reach, at elaboration
  if (LOCK_CYC < 1 || LOCK_CYC >= (1 << LOCK_CNT_W)) begin : g_bad_lock_cyc
    $error("LOCK_CYC out of range");
  end

  // ==========================================================
  // reset release synchroniser
  logic rst_meta_r;
  logic rst_sync_r;

  // assertion is immediate, release passes two flops
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_r <= 1'b0; // RL13
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r; // RL13
    end
  end

  // ==========================================================
  // stage machine
  hub_stage_e                stage_r;
  hub_stage_e                stage_nxt;
  logic [LOCK_CNT_W-1:0]     lock_cnt_r;
  logic                      lock_done;

  assign lock_done = (lock_cnt_r == LOCK_CYC[LOCK_CNT_W-1:0]) && i_pll_locked;

  always_comb begin
    stage_nxt = stage_r;
    unique case (stage_r)
      ST_STANDBY:  if (rst_sync_r) stage_nxt = ST_PLL_WAIT; // RL1
      ST_PLL_WAIT: if (lock_done) stage_nxt = ST_CFG_LOAD; // RL12
      ST_CFG_LOAD: if (i_cfg_done) stage_nxt = ST_ATTACH; // RL6
      ST_ATTACH:   if (i_host_attached && !i_soft_disconnect) stage_nxt = ST_NORMAL; // RL6
      ST_NORMAL:   if (i_soft_disconnect) stage_nxt = ST_ATTACH; // RL6
    endcase
  end

  // async reset puts everything back to defaults in one step
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stage_r <= ST_STANDBY; // RL1 RL4
    end else if (!rst_sync_r) begin
      stage_r <= ST_STANDBY;
    end else begin
      stage_r <= stage_nxt;
    end
  end

  // pll lock wait counter restarts on every standby exit
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lock_cnt_r <= '0;
    end else if (stage_r != ST_PLL_WAIT) begin
      lock_cnt_r <= '0;
    end else if (lock_cnt_r != LOCK_CYC[LOCK_CNT_W-1:0]) begin
      lock_cnt_r <= lock_cnt_r + 1'b1; // RL12
    end
  end

  // ==========================================================
  // mode control outputs
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ctrl    <= CTRL_STANDBY; // RL2 RL5
      o_standby <= 1'b1;
      o_stage   <= ST_STANDBY;
    end else begin
      o_standby           <= (stage_nxt == ST_STANDBY) || !rst_sync_r;
      o_stage             <= rst_sync_r ? stage_nxt : ST_STANDBY;
      o_ctrl.core_pwr_en  <= rst_sync_r; // RL5
      o_ctrl.pll_run      <= rst_sync_r; // RL2
      o_ctrl.cfg_load     <= rst_sync_r && (stage_nxt == ST_CFG_LOAD); // RL4 RL12
      o_ctrl.ports_drive  <= rst_sync_r && (stage_nxt != ST_STANDBY); // RL2
      o_ctrl.xact_enable  <= rst_sync_r && (stage_nxt == ST_NORMAL); // RL3
    end
  end

  // ==========================================================
  // phy enables from logical port enables
  logic [NUM_U2_PHY-1:0] u2_en;
  logic [NUM_U3_PHY-1:0] u3_en;
  logic                  run_ok;

  assign run_ok = rst_sync_r && (stage_nxt == ST_NORMAL || stage_nxt == ST_ATTACH);

  always_comb begin
    u2_en = '0;
    u3_en = '0;
    for (int lp = 0; lp < NUM_LOG_PORT; lp++) begin
      if (i_ds_port_en[lp] || lp == 0) begin
        u2_en[U2_MAP[lp]] = 1'b1; // RL8 RL10
        if (U3_PRESENT[lp]) begin
          u3_en[U3_MAP_A[lp]] = 1'b1; // RL11
          u3_en[U3_MAP_B[lp]] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_u2_phy_en <= '0; // RL3
      o_u3_phy_en <= '0;
    end else begin
      o_u2_phy_en <= run_ok ? u2_en : '0; // RL3 RL7
      o_u3_phy_en <= run_ok ? u3_en : '0;
    end
  end

  // ==========================================================
  // per-setting port number translation
  port_num_t lk_u2;
  port_num_t lk_a;
  port_num_t lk_b;

  always_comb begin
    lk_u2 = i_set_port;
    lk_a  = i_set_port;
    lk_b  = i_set_port;
    if (i_set_is_logical) begin
      if (i_set_port < NUM_LOG_PORT[PORT_W-1:0]) begin
        lk_u2 = U2_MAP[i_set_port]; // RL9
        lk_a  = U3_MAP_A[i_set_port];
        lk_b  = U3_MAP_B[i_set_port];
      end else begin
        lk_u2 = 3'h7;
        lk_a  = 3'h7;
        lk_b  = 3'h7;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_set_u2_phy   <= '0;
      o_set_u3_phy_a <= '0;
      o_set_u3_phy_b <= '0;
    end else begin
      o_set_u2_phy   <= lk_u2; // RL9
      o_set_u3_phy_a <= lk_a;
      o_set_u3_phy_b <= lk_b;
    end
  end

  // ==========================================================
  // checks
  chk_standby_ports: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !rst_sync_r |=> (o_u2_phy_en == '0) && !o_ctrl.ports_drive && !o_ctrl.pll_run) // RL2
    else $error("ports or pll active in standby");
  chk_standby_xact: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !rst_sync_r |=> !o_ctrl.xact_enable && (o_u3_phy_en == '0)) // RL3
    else $error("transactions alive in standby");
  chk_core_power: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_ctrl.core_pwr_en == $past(rst_sync_r)) // RL5
    else $error("core power not following mode");
  chk_release_sync: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(rst_sync_r) |-> $past(rst_meta_r) && stage_r == ST_STANDBY) // RL13
    else $error("release not synchronised");
  chk_mode_select: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    stage_r == ST_STANDBY && rst_sync_r |=> stage_r == ST_PLL_WAIT) // RL1
    else $error("hub mode not entered");
  chk_lock_wait: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    stage_r == ST_CFG_LOAD && $past(stage_r) == ST_PLL_WAIT
      |-> $past(lock_cnt_r) == LOCK_CYC[LOCK_CNT_W-1:0]) // RL12
    else $error("config load before pll lock time");
  chk_cfg_defaults: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    stage_r == ST_ATTACH && $past(stage_r) == ST_CFG_LOAD |-> $past(i_cfg_done)) // RL4
    else $error("attach without configuration reload");
  chk_u2_map: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_set_is_logical && i_set_port == 3'h4 |=> o_set_u2_phy == 3'h2) // RL10
    else $error("usb2 remap wrong");
  chk_u3_map: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_set_is_logical && i_set_port == 3'h2 |=> o_set_u3_phy_a == 3'h3 && o_set_u3_phy_b == 3'h4) // RL11
    else $error("usb3 remap wrong");
  chk_phys_pass: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !i_set_is_logical |=> o_set_u2_phy == $past(i_set_port)) // RL9
    else $error("physical setting altered");
  chk_upstream_on: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    stage_r == ST_NORMAL && rst_sync_r && $past(rst_sync_r) |=> o_u2_phy_en[0]) // RL8 RL6
    else $error("upstream phy off in normal mode");
  chk_standby_flag: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !rst_sync_r |=> o_standby) // RL1
    else $error("standby flag low in standby");
  chk_stage_mirror: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_stage == stage_r) // RL6
    else $error("stage output differs from stage");
  chk_cfg_load_only: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_ctrl.cfg_load |-> stage_r == ST_CFG_LOAD) // RL12
    else $error("config load outside load stage");
  chk_xact_normal: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_ctrl.xact_enable |-> stage_r == ST_NORMAL) // RL3
    else $error("transactions outside normal stage");
  chk_u3_unused: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_set_is_logical && i_set_port == 3'h4 |=> o_set_u3_phy_a == 3'h7) // RL11
    else $error("usb3 map given for usb2-only port");
  chk_pll_hold: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    stage_r == ST_PLL_WAIT && !i_pll_locked |=> stage_r != ST_CFG_LOAD) // RL12
    else $error("config load without pll lock");
  chk_soft_disc: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    stage_r == ST_NORMAL && i_soft_disconnect && rst_sync_r |=> stage_r == ST_ATTACH) // RL6
    else $error("soft disconnect ignored");
  chk_phy_idle_early: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (stage_r == ST_PLL_WAIT || stage_r == ST_CFG_LOAD) |-> o_u2_phy_en == '0) // RL3
    else $error("phys enabled before attach");

endmodule

//--- hub_reset_source.sv
// Purpose: system-side model of reset pin, pll lock and config loader
// Assumes: levels change 1 ns after the clock edge
// Notes:   lock is lost at the first clock edge after the pll is halted
`timescale 1ns/1ps

module hub_reset_source #(
  parameter int LOCK_DLY = 6
) (
  // requests from the bench
  input  wire logic i_clk,
  input  wire logic i_hold_reset,
  input  wire logic i_slow,
  // levels from the hub
  input  wire logic i_pll_run,
  input  wire logic i_cfg_load,
  // levels to the hub
  output logic      o_reset_n = 1'b0,
  output logic      o_pll_locked = 1'b0,
  output logic      o_cfg_done = 1'b0
);
  int lock_cnt = 0;
  int cfg_cnt = 0;

  // ==========
  // a halted pll never reports lock
  always @(posedge i_clk) begin
    lock_cnt <= i_pll_run ? lock_cnt + 1 : 0;
    cfg_cnt <= i_cfg_load ? cfg_cnt + 1 : 0;
    o_reset_n <= #1 !i_hold_reset;
    o_pll_locked <= #1 i_pll_run && lock_cnt >= LOCK_DLY;
    o_cfg_done <= #1 i_cfg_load && cfg_cnt == (i_slow ? 20 : 2);
  end
endmodule

//--- test_hub_standby_mode_and_port_map.sv
// Purpose: self-checking bench for standby control and port lookup
// Assumes: lock wait shortened to 4 cycles
// Notes:   reset pin comes from the reset source model
`timescale 1ns/1ps

module test_hub_standby_mode_and_port_map;
  import hub_mode_pkg::*;
  // ==========
  // stimulus and wiring
  logic                    clk = 1'b0;
  logic                    hold_rst = 1'b1;
  logic                    slow = 1'b0;
  logic                    attached = 1'b0;
  logic                    soft_dis = 1'b0;
  logic                    is_log = 1'b1;
  logic [PORT_W-1:0]       set_port = '0;
  logic [NUM_LOG_PORT-1:0] ds_en = '0;
  wire logic               rst_n;
  wire logic               locked;
  wire logic               cfg_done;
  logic                    standby;
  hub_ctrl_s               ctrl;
  hub_stage_e              stage;
  logic [NUM_U2_PHY-1:0]   u2_en;
  logic [NUM_U3_PHY-1:0]   u3_en;
  logic [PORT_W-1:0]       m_u2, m_a, m_b;
  int                      err_total = 0;
  int                      comparisons = 0;
  int                      cyc = 0;

  always #2 clk = ~clk;

  hub_reset_source i_hub_reset_source (.i_clk(clk), .i_hold_reset(hold_rst), .i_slow(slow),
    .i_pll_run(ctrl.pll_run), .i_cfg_load(ctrl.cfg_load), .o_reset_n(rst_n),
    .o_pll_locked(locked), .o_cfg_done(cfg_done));

  hub_mode_ctrl #(.LOCK_CYC(4)) i_hub_mode_ctrl (.i_clk(clk), .i_reset_n(rst_n),
    .i_pll_locked(locked), .i_cfg_done(cfg_done), .i_host_attached(attached),
    .i_soft_disconnect(soft_dis), .i_set_port(set_port), .i_set_is_logical(is_log),
    .i_ds_port_en(ds_en), .o_standby(standby), .o_ctrl(ctrl), .o_stage(stage),
    .o_u2_phy_en(u2_en), .o_u3_phy_en(u3_en), .o_set_u2_phy(m_u2),
    .o_set_u3_phy_a(m_a), .o_set_u3_phy_b(m_b));

  // ==========
  // expectations
  function automatic logic [8:0] exp_map(input int l);
    logic [2:0] u2 [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h2};
    logic [2:0] a [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};
    logic [2:0] b [5] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h7};
    return (l > 4) ? 9'h1ff : {u2[l], a[l], b[l]};
  endfunction

  // u3 enables in bits 12:7, u2 in 6:0
  function automatic logic [12:0] exp_phy(input logic [4:0] en);
    logic [12:0] r;
    logic [8:0]  m;
    r = '0;
    for (int l = 0; l < 5; l++) begin
      m = exp_map(l);
      if (en[l] || l == 0) begin
        r[m[8:6]] = 1'b1;
        if (l < 4) begin
          r[7 + m[5:3]] = 1'b1;
          r[7 + m[2:0]] = 1'b1;
        end
      end
    end
    return r;
  endfunction

  // ==========
  // shared tasks
  task automatic step();
    @(posedge clk);
    #1;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_stage(input hub_stage_e s, input int lim);
    int n = 0;
    while (stage !== s && n < lim) begin
      step();
      n++;
    end
    cmp(16'(stage), 16'(s), "stage");
  endtask

  task automatic chk_standby();
    cmp(16'(standby), 16'h1, "standby flag");
    cmp(16'(ctrl), 16'h0, "ctrl in standby");
    cmp(16'(stage), 16'(ST_STANDBY), "stage in standby");
    cmp({3'h0, u3_en, u2_en}, 16'h0, "phy enables");
  endtask

  task automatic walk_up();
    wait_stage(ST_PLL_WAIT, 8);
    cmp(16'(standby), 16'h0, "standby flag");
    cmp(16'(ctrl), 16'h1c, "ctrl in pll wait");
    wait_stage(ST_CFG_LOAD, 40);
    cmp(16'(ctrl.cfg_load), 16'h1, "cfg load");
    wait_stage(ST_ATTACH, 40);
    step();
    cmp({3'h0, u3_en, u2_en}, 16'(exp_phy(ds_en)), "phy enables");
    attached = 1'b1;
    wait_stage(ST_NORMAL, 8);
    cmp(16'(ctrl.xact_enable), 16'h1, "xact enable");
  endtask

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ==========
  // scenarios
  initial begin
    void'($urandom(66540));
    repeat (12) step();
    chk_standby();
    ds_en = 5'($urandom());
    hold_rst = 1'b0;
    walk_up();
    // every logical number in turn, then random, physical ones mixed in
    for (int i = 0; i < 48; i++) begin
      set_port = (i < 8) ? 3'(i) : 3'($urandom());
      is_log = (i < 8) ? 1'b1 : 1'($urandom());
      step();
      if (is_log)
        cmp({7'h0, m_u2, m_a, m_b}, 16'(exp_map(set_port)), "map");
      else
        cmp({7'h0, m_u2, m_a, m_b}, {7'h0, set_port, set_port, set_port}, "phys");
    end
    is_log = 1'b1;
    soft_dis = 1'b1;
    wait_stage(ST_ATTACH, 8);
    soft_dis = 1'b0;
    wait_stage(ST_NORMAL, 8);
    // reset in mid-run, then a slow config load
    hold_rst = 1'b1;
    step();
    step();
    chk_standby();
    attached = 1'b0;
    slow = 1'b1;
    ds_en = 5'h1b;
    step();
    hold_rst = 1'b0;
    walk_up();
    tally_and_finish();
  end
endmodule
